// *** hdl/sac_top.sv ***
// Converter control: APB registers, conversion sequencer, trigger, interrupt.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// - Successive approximation, one comparator decision per bit, 10-bit result.
// - High byte holds top eight bits; low byte bits 7:6 hold bottom two.
// - Result readable always; held from conversion end until the next conversion end.
// - Reset does not clear the result registers.
// - Mode register resets to 30 hex: speed, trigger enable, channel.
// - Speed bit clear gives 62 clocks per conversion, set gives 31.
// - Trigger enable gates starting by trigger pin edges.
// - Trigger edge polarity comes from the edge select register bit.
// - Mode bits 5 and 4 read one and ignore writes.
// - Channel codes 00xx select nothing; 0100-1111 select inputs 0 to 11.
// - A request is raised when each conversion finishes.
// - Standby bit in clock stop register 1 freezes the converter when clear; it resets set.
// - Writing one or a trigger edge starts; writing zero stops; end clears.
// - Flag falling at conversion end sets done request; enable gates interrupt.
module sac_top import sac_pkg::*; (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_TRIGGER_PIN,
  input wire logic COMPARATOR_HIGH,
  output logic [9:0] LADDER_CODE,
  output logic [11:0] ANALOG_INPUTS_SELECT,
  output logic SAMPLE_HOLD,
  output logic CONV_DONE_IRQ
);

  function automatic logic [11:0] chan_decode(input logic [3:0] code);
    logic [11:0] sel;
    sel = 12'h000;
    if (code[3:2] != 2'b00) begin
      sel[4'(code - 4'h4)] = 1'b1;
    end
    return sel;
  endfunction

  sac_state_t state_r, state_nxt;
  sac_mode_t mode_r, mode_nxt;
  sac_result_t result_r, result_nxt;
  logic [9:0] trial_r, trial_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [5:0] count_r, count_nxt;
  logic [5:0] length_r, length_nxt;
  logic start_flag_r, start_flag_nxt;
  logic [7:0] clk_stop1_r, clk_stop1_nxt;
  logic [7:0] irq_edge_r, irq_edge_nxt;
  logic stat_r, stat_nxt;
  logic mask_r, mask_nxt;
  logic [2:0] trig_sync_r;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, irq_nxt;
  logic [11:0] sel_nxt;
  logic hold_nxt;
  logic [9:0] ladder_nxt;

  logic apb_acc, apb_wr, apb_rd, awake, trig_edge, start_req, stop_req, conv_end;
  logic [3:0] bit_dec;

  assign apb_acc = PSEL && PENABLE && !PREADY;
  assign apb_wr = apb_acc && PWRITE;
  assign apb_rd = apb_acc && !PWRITE;
  assign awake = clk_stop1_r[SAC_BIT_STANDBY];
  // Edge detect only on the second and third stages
  assign trig_edge = irq_edge_r[SAC_BIT_TRIG_EDGE] ?
                     (trig_sync_r[1] && !trig_sync_r[2]) :
                     (!trig_sync_r[1] && trig_sync_r[2]);
  assign start_req = awake && !start_flag_r &&
                     ((apb_wr && PADDR == SAC_OFS_START && PWDATA[SAC_BIT_START_FLAG]) ||
                      (mode_r.trig_en && trig_edge));
  assign stop_req = apb_wr && PADDR == SAC_OFS_START && !PWDATA[SAC_BIT_START_FLAG];
  assign conv_end = state_r == SAC_RUN && count_r == length_r - 6'h01;
  assign bit_dec = bit_r - 4'h1;

  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    result_nxt = result_r;
    trial_nxt = trial_r;
    bit_nxt = bit_r;
    count_nxt = count_r;
    length_nxt = length_r;
    start_flag_nxt = start_flag_r;
    clk_stop1_nxt = clk_stop1_r;
    irq_edge_nxt = irq_edge_r;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (apb_wr) begin
      case (PADDR)
        SAC_OFS_MODE: begin
          mode_nxt.speed = PWDATA[SAC_BIT_SPEED];
          mode_nxt.trig_en = PWDATA[SAC_BIT_TRIG_EN];
          mode_nxt.channel = PWDATA[3:0];
        end
        SAC_OFS_CLK_STOP1: clk_stop1_nxt = PWDATA[7:0];
        SAC_OFS_IRQ_EDGE: irq_edge_nxt = PWDATA[7:0];
        SAC_OFS_IRQ_MASK: mask_nxt = PWDATA[SAC_BIT_DONE];
        default: ;
      endcase
    end
    if (awake) begin
      case (state_r)
        SAC_IDLE: begin
          if (start_req) begin
            start_flag_nxt = 1'b1;
            length_nxt = mode_r.speed ? SAC_CONV_FAST_CYC : SAC_CONV_SLOW_CYC;
            count_nxt = 6'h00;
            trial_nxt = 10'h200;
            bit_nxt = 4'(SAC_RESULT_W);
            state_nxt = SAC_SAMPLE;
          end
        end
        SAC_SAMPLE: begin
          count_nxt = count_r + 6'h01;
          state_nxt = SAC_RUN;
        end
        SAC_RUN: begin
          count_nxt = count_r + 6'h01;
          if (bit_r != 4'h0) begin
            // Keep or drop the trial bit, then try the next lower one
            if (!COMPARATOR_HIGH) begin
              trial_nxt[bit_dec] = 1'b0;
            end
            if (bit_dec != 4'h0) begin
              trial_nxt[4'(bit_dec - 4'h1)] = 1'b1;
            end
            bit_nxt = bit_dec;
          end
          if (conv_end) begin
            result_nxt.data = trial_nxt;
            start_flag_nxt = 1'b0;
            state_nxt = SAC_IDLE;
          end
        end
        default: state_nxt = SAC_IDLE;
      endcase
      if (stop_req && state_r != SAC_IDLE) begin
        start_flag_nxt = 1'b0;
        state_nxt = SAC_IDLE;
      end
    end
    if (apb_rd && PADDR == SAC_OFS_IRQ_STAT) begin
      stat_nxt = 1'b0;
    end
    if (awake && conv_end) begin
      stat_nxt = 1'b1;
    end
  end

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    if (apb_rd) begin
      case (PADDR)
        SAC_OFS_RES_HIGH: prdata_nxt[7:0] = result_r.data[9:2];
        SAC_OFS_RES_LOW: prdata_nxt[7:0] = {result_r.data[1:0], 6'h00};
        SAC_OFS_MODE: prdata_nxt[7:0] = {mode_r.speed, mode_r.trig_en,
                                         SAC_MODE_FIXED[5:4], mode_r.channel};
        SAC_OFS_START: prdata_nxt[7:0] = {start_flag_r, SAC_START_RESERVED[6:0]};
        SAC_OFS_CLK_STOP1: prdata_nxt[7:0] = clk_stop1_r;
        SAC_OFS_IRQ_EDGE: prdata_nxt[7:0] = irq_edge_r;
        SAC_OFS_IRQ_STAT: prdata_nxt[SAC_BIT_DONE] = stat_r;
        SAC_OFS_IRQ_MASK: prdata_nxt[SAC_BIT_DONE] = mask_r;
        default: pslverr_nxt = 1'b1;
      endcase
    end else if (apb_wr) begin
      case (PADDR)
        SAC_OFS_MODE, SAC_OFS_START, SAC_OFS_CLK_STOP1, SAC_OFS_IRQ_EDGE,
        SAC_OFS_IRQ_MASK, SAC_OFS_RES_HIGH, SAC_OFS_RES_LOW, SAC_OFS_IRQ_STAT: ;
        default: pslverr_nxt = 1'b1;
      endcase
    end
    pready_nxt = apb_acc;
    irq_nxt = stat_nxt && mask_nxt;
    sel_nxt = (state_nxt == SAC_IDLE) ? 12'h000 : chan_decode(mode_nxt.channel);
    hold_nxt = state_nxt == SAC_SAMPLE;
    ladder_nxt = trial_nxt;
  end

  // Software-visible control registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_r <= sac_mode_t'({SAC_MODE_RESET[7:6], SAC_MODE_RESET[3:0]});
      clk_stop1_r <= SAC_CLK_STOP1_RESET;
      irq_edge_r <= SAC_IRQ_EDGE_RESET;
      mask_r <= 1'b0;
    end else if (CLK_EN) begin
      mode_r <= mode_nxt;
      clk_stop1_r <= clk_stop1_nxt;
      irq_edge_r <= irq_edge_nxt;
      mask_r <= mask_nxt;
    end
  end

  // Conversion sequencer
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= SAC_IDLE;
      trial_r <= 10'h000;
      bit_r <= 4'h0;
      count_r <= 6'h00;
      length_r <= SAC_CONV_SLOW_CYC;
      start_flag_r <= 1'b0;
    end else if (CLK_EN) begin
      state_r <= state_nxt;
      trial_r <= trial_nxt;
      bit_r <= bit_nxt;
      count_r <= count_nxt;
      length_r <= length_nxt;
      start_flag_r <= start_flag_nxt;
    end
  end

  // Sticky completion status
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      stat_r <= 1'b0;
    end else if (CLK_EN) begin
      stat_r <= stat_nxt;
    end
  end

  // Trigger pin synchroniser and edge history
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      trig_sync_r <= 3'h0;
    end else if (CLK_EN) begin
      trig_sync_r <= {trig_sync_r[1:0], EXT_TRIGGER_PIN};
    end
  end

  // Bus answer
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CLK_EN) begin
      PRDATA <= prdata_nxt;
      PREADY <= pready_nxt;
      PSLVERR <= pslverr_nxt;
    end
  end

  // Pins toward the analog side and the interrupt line
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CONV_DONE_IRQ <= 1'b0;
      ANALOG_INPUTS_SELECT <= 12'h000;
      SAMPLE_HOLD <= 1'b0;
      LADDER_CODE <= 10'h000;
    end else if (CLK_EN) begin
      CONV_DONE_IRQ <= irq_nxt;
      ANALOG_INPUTS_SELECT <= sel_nxt;
      SAMPLE_HOLD <= hold_nxt;
      LADDER_CODE <= ladder_nxt;
    end
  end

  // Result keeps its value through reset
  always_ff @(posedge CLK) begin
    if (CLK_EN) begin
      result_r <= result_nxt;
    end
  end

endmodule // sac_top

// *** hdl/sac_pkg.sv ***
// Package for the converter control block: offsets, fields, reset values, types.
package sac_pkg;
  localparam logic [15:0] SAC_OFS_RES_HIGH = 16'hFFC4;
  localparam logic [15:0] SAC_OFS_RES_LOW = 16'hFFC5;
  localparam logic [15:0] SAC_OFS_MODE = 16'hFFC6;
  localparam logic [15:0] SAC_OFS_START = 16'hFFC7;
  localparam logic [15:0] SAC_OFS_CLK_STOP1 = 16'hFFFA;
  localparam logic [15:0] SAC_OFS_IRQ_EDGE = 16'hFFF0;
  localparam logic [15:0] SAC_OFS_IRQ_STAT = 16'hFFF1;
  localparam logic [15:0] SAC_OFS_IRQ_MASK = 16'hFFF2;
  localparam logic [7:0] SAC_MODE_RESET = 8'h30;
  localparam logic [7:0] SAC_MODE_FIXED = 8'h30;
  localparam logic [7:0] SAC_START_RESERVED = 8'h7F;
  localparam logic [7:0] SAC_CLK_STOP1_RESET = 8'hFF;
  localparam logic [7:0] SAC_IRQ_EDGE_RESET = 8'h00;
  localparam int SAC_BIT_SPEED = 7;
  localparam int SAC_BIT_TRIG_EN = 6;
  localparam int SAC_BIT_START_FLAG = 7;
  localparam int SAC_BIT_STANDBY = 4;
  localparam int SAC_BIT_TRIG_EDGE = 4;
  localparam int SAC_BIT_DONE = 0;
  localparam int SAC_RESULT_W = 10;
  localparam int SAC_CLK_MHZ = 100;
  localparam int SAC_CONV_SLOW_PHI = 62;
  localparam int SAC_CONV_FAST_PHI = 31;
  localparam logic [5:0] SAC_CONV_SLOW_CYC = 6'(SAC_CONV_SLOW_PHI);
  localparam logic [5:0] SAC_CONV_FAST_CYC = 6'(SAC_CONV_FAST_PHI);
  localparam int SAC_STANDBY_WAKE_CYC = 10;

  typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_RUN} sac_state_t;

  typedef struct packed {
    logic speed;
    logic trig_en;
    logic [3:0] channel;
  } sac_mode_t;

  typedef struct packed {
    logic [SAC_RESULT_W-1:0] data;
  } sac_result_t;
endpackage

// *** dv/sac_monitor.sv ***
// Port checker for the converter control block
`timescale 1ns/10ps
module sac_monitor import sac_pkg::*; (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [11:0] ANALOG_INPUTS_SELECT,
  input wire logic SAMPLE_HOLD
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence s_acc;
    PSEL && PENABLE && !PREADY && CLK_EN;
  endsequence
  sequence s_rd(logic [15:0] a);
    PREADY && !PWRITE && PADDR == a;
  endsequence
  property p_answer; s_acc |=> PREADY; endproperty
  property p_pulse; PREADY |=> !PREADY; endproperty
  property p_err; PSLVERR |-> PREADY; endproperty
  property p_mode; s_rd(SAC_OFS_MODE) |-> PRDATA[5:4] == 2'b11; endproperty
  property p_start; s_rd(SAC_OFS_START) |-> PRDATA[6:0] == 7'h7F; endproperty
  property p_sh; SAMPLE_HOLD |=> (!SAMPLE_HOLD)[*8]; endproperty
  property p_sel; $onehot0(ANALOG_INPUTS_SELECT); endproperty
  property p_sel_hold; $fell(SAMPLE_HOLD) |-> $stable(ANALOG_INPUTS_SELECT); endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_err: assert property (p_err) else $error("error without ready");
  a_mode: assert property (p_mode) else $error("mode fixed bits");
  a_start: assert property (p_start) else $error("start fixed bits");
  a_sh: assert property (p_sh) else $error("restart while busy");
  a_sel: assert property (p_sel) else $error("select not one hot");
  a_sel_hold: assert property (p_sel_hold) else $error("select moved");
endmodule // sac_monitor
bind sac_top sac_monitor u_mon (.CLK, .RST_B, .CLK_EN, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PRDATA, .PREADY, .PSLVERR, .ANALOG_INPUTS_SELECT, .SAMPLE_HOLD);

// *** dv/sac_analog_model.sv ***
// Ideal analog front end: one fixed level per input
`timescale 1ns/10ps
module sac_analog_model (
  input wire logic [11:0] ANALOG_INPUTS_SELECT,
  input wire logic [9:0] LADDER_CODE,
  output logic COMPARATOR_HIGH
);
  logic [9:0] lvl;
  always_comb begin
    lvl = 10'h000;
    for (int i = 0; i < 12; i++) begin
      if (ANALOG_INPUTS_SELECT[i]) lvl = 10'(i * 83 + 5);
    end
    COMPARATOR_HIGH = lvl >= LADDER_CODE;
  end
endmodule // sac_analog_model

// *** dv/test_sac_top.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module test_sac_top import sac_pkg::*; ;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, trig = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic pready, pslverr, cmp, sh, irq, e;
  logic [9:0] ladder;
  logic [11:0] sel;
  logic [7:0] q;
  int mismatches = 0, compares = 0, n;
  always #5 clk = ~clk;
  sac_top u_dut (.CLK(clk), .RST_B(rst_b), .CLK_EN(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_TRIGGER_PIN(trig), .COMPARATOR_HIGH(cmp), .LADDER_CODE(ladder),
    .ANALOG_INPUTS_SELECT(sel), .SAMPLE_HOLD(sh), .CONV_DONE_IRQ(irq));
  sac_analog_model u_ana (.ANALOG_INPUTS_SELECT(sel), .LADDER_CODE(ladder),
    .COMPARATOR_HIGH(cmp));
  task chk(input string s, input logic [11:0] g, input logic [11:0] x);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s exp %h got %h", s, x, g);
    end
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(negedge clk);
    while (pready !== 1'b1) @(negedge clk);
    q = prdata[7:0];
    e = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task conv(input logic [7:0] m, input int ch, input int l);
    logic [9:0] v;
    v = 10'(ch * 83 + 5);
    apb(1'b1, SAC_OFS_MODE, m);
    apb(1'b1, SAC_OFS_START, 8'h80);
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
      if (n == 2) chk("select", sel, 12'h001 << ch);
    end
    chk("length", 12'(n), 12'(l));
    apb(1'b0, SAC_OFS_RES_HIGH, 8'h00);
    chk("high", 12'(q), 12'(v[9:2]));
    apb(1'b0, SAC_OFS_RES_LOW, 8'h00);
    chk("low", 12'(q[7:6]), 12'(v[1:0]));
    apb(1'b0, SAC_OFS_START, 8'h00);
    chk("flag", 12'(q), 12'h07F);
    apb(1'b0, SAC_OFS_IRQ_STAT, 8'h00);
    chk("status", 12'(q[0]), 12'h001);
    @(posedge clk);
    chk("irq", 12'(irq), 12'h000);
  endtask
  task trg(input logic [7:0] m, input logic [7:0] g, input logic t, input logic x);
    apb(1'b1, SAC_OFS_MODE, m);
    apb(1'b1, SAC_OFS_IRQ_EDGE, g);
    trig <= t;
    repeat (80) @(posedge clk);
    chk("masked", 12'(irq), 12'h000);
    apb(1'b0, SAC_OFS_IRQ_STAT, 8'h00);
    chk("trigger", 12'(q[0]), 12'(x));
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, SAC_OFS_MODE, 8'h00);
    chk("mode", 12'(q), 12'h030);
    apb(1'b0, SAC_OFS_CLK_STOP1, 8'h00);
    chk("stop", 12'(q), 12'h0FF);
    apb(1'b1, SAC_OFS_MODE, 8'hCF);
    apb(1'b0, SAC_OFS_MODE, 8'h00);
    chk("mode", 12'(q), 12'h0FF);
    apb(1'b0, 16'h0000, 8'h00);
    chk("unmapped", 12'(e), 12'h001);
    apb(1'b1, SAC_OFS_IRQ_MASK, 8'h01);
    conv(8'h05, 1, 62);
    conv(8'h8F, 11, 31);
    conv(8'hC4, 0, 31);
    conv(8'h08, 4, 62);
    apb(1'b1, SAC_OFS_MODE, 8'h02);
    apb(1'b1, SAC_OFS_START, 8'h80);
    @(posedge clk);
    chk("none", sel, 12'h000);
    apb(1'b1, SAC_OFS_START, 8'h00);
    repeat (70) @(posedge clk);
    apb(1'b0, SAC_OFS_IRQ_STAT, 8'h00);
    chk("stopped", 12'(q[0]), 12'h000);
    apb(1'b1, SAC_OFS_CLK_STOP1, 8'hEF);
    apb(1'b1, SAC_OFS_START, 8'h80);
    apb(1'b0, SAC_OFS_START, 8'h00);
    chk("standby", 12'(q), 12'h07F);
    apb(1'b1, SAC_OFS_CLK_STOP1, 8'hFF);
    repeat (10) @(posedge clk);
    apb(1'b1, SAC_OFS_IRQ_MASK, 8'h00);
    trg(8'h04, 8'h10, 1'b1, 1'b0);
    trg(8'h44, 8'h10, 1'b0, 1'b0);
    trg(8'h44, 8'h10, 1'b1, 1'b1);
    trg(8'h44, 8'h00, 1'b0, 1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, SAC_OFS_RES_HIGH, 8'h00);
    chk("kept", 12'(q), 12'h001);
    apb(1'b0, SAC_OFS_MODE, 8'h00);
    chk("mode", 12'(q), 12'h030);
    conclude;
  end
endmodule // test_sac_top
